//--- verilog/drhd_pkg.sv
// Constants shared by the dataset range hint decoder and its helpers.
// Assumes a 32-bit AHB-Lite register bus and a single clock domain.
package drhd_pkg;
  // ********************************************************************
  // Register word indices (byte address = index * 4)
  // ********************************************************************
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_CDW10  = 4'h2;
  localparam logic [3:0] REG_CDW11  = 4'h3;
  localparam logic [3:0] REG_DPTR0  = 4'h4;
  localparam logic [3:0] REG_DPTR3  = 4'h7;
  // ********************************************************************
  // Field positions
  // ********************************************************************
  localparam int CTRL_START_BIT    = 0;
  localparam int CTRL_CONFLICT_BIT = 1;
  localparam int CTRL_SGL_BIT      = 2;
  localparam int CDW11_IDR_BIT     = 0;
  localparam int CDW11_IDW_BIT     = 1;
  localparam int CDW11_DEALLOC_BIT = 2;
  localparam int ATTR_WP_BIT       = 10;
  localparam int ATTR_SW_BIT       = 9;
  localparam int ATTR_SR_BIT       = 8;
  localparam int ATTR_CAS_LSB      = 24;
  localparam int ATTR_AL_LSB       = 4;
  localparam int ATTR_AF_LSB       = 0;
  // ********************************************************************
  // Values after reset, codes, sizes
  // ********************************************************************
  localparam logic [31:0] RST_WORD       = 32'h0000_0000;
  localparam logic [3:0]  AF_LAST_VALID  = 4'h5;
  localparam logic [7:0]  STATUS_OK      = 8'h00;
  localparam logic [7:0]  STATUS_CONFLICT = 8'h80;
  localparam logic [12:0] PAGE_BYTES     = 13'h1000;
  localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
endpackage : drhd_pkg

//--- verilog/drhd_reg_if.sv
// Register access carrier between the bus front end and the core.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface drhd_reg_if;
  logic        wr_en;    // One-cycle write strobe
  logic [3:0]  wr_idx;   // Word index of write
  logic [31:0] wr_data;  // Write data
  logic [3:0]  rd_idx;   // Word index of read
  logic [31:0] rd_data;  // Read data, combinational
  modport front (output wr_en, wr_idx, wr_data, rd_idx, input rd_data);
  modport core  (input wr_en, wr_idx, wr_data, rd_idx, output rd_data);
endinterface : drhd_reg_if
`default_nettype wire

//--- verilog/drhd_ahb_front.sv
// AHB-Lite slave front end: writes with no wait, reads with one wait.
// Assumes single word transfers; answer is always OKAY.
`timescale 1ns/1ps
`default_nettype none
module drhd_ahb_front
  import drhd_pkg::*;
(
  input  wire logic        hclk,      // Bus clock
  input  wire logic        hresetn,   // Async reset, low
  input  wire logic        hsel,      // Slave select
  input  wire logic [31:0] haddr,     // Byte address
  input  wire logic [1:0]  htrans,    // Transfer type
  input  wire logic        hwrite,    // Write when high
  input  wire logic [31:0] hwdata,    // Write data
  input  wire logic        hready,    // Bus ready
  output logic             hreadyout, // Slave ready
  output logic [31:0]      hrdata,    // Read data
  drhd_reg_if.front        rif        // Register side
);
  logic       wr_pend_q;
  logic       rd_pend_q;
  logic       rd_wait_q;
  logic [3:0] idx_q;
  logic [31:0] hrdata_q;
  wire        take = hsel & htrans[1] & hready;
  // Unmapped high address bits fold into index 15, which reads zero
  wire [3:0]  idx_now = (haddr[31:6] == 26'h0) ? haddr[5:2] : 4'hf;

  // Reads stall one cycle so a preceding write is always seen
  assign hreadyout   = ~(rd_pend_q & ~rd_wait_q);
  assign hrdata      = hrdata_q;
  assign rif.wr_en   = wr_pend_q;
  assign rif.wr_idx  = idx_q;
  assign rif.wr_data = hwdata;
  assign rif.rd_idx  = idx_q;

  // Address phase capture
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      idx_q     <= 4'h0;
    end
    else if (hreadyout)
    begin
      wr_pend_q <= take & hwrite;
      rd_pend_q <= take & ~hwrite;
      idx_q     <= idx_now;
    end
  end

  // Read data registered in the wait cycle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rd_wait_q <= 1'b0;
      hrdata_q  <= RST_WORD;
    end
    else
    begin
      rd_wait_q <= rd_pend_q & ~rd_wait_q;
      if (rd_pend_q & ~rd_wait_q)
        hrdata_q <= rif.rd_data;
    end
  end
endmodule : drhd_ahb_front
`default_nettype wire

//--- verilog/drhd_attr_decode.sv
// Combinational decode of one range's context attribute word.
// Assumes the caller registers the outputs.
`timescale 1ns/1ps
`default_nettype none
module drhd_attr_decode
  import drhd_pkg::*;
(
  input  wire logic [31:0] attr,          // Attribute word
  output logic [7:0]       access_size,   // Blocks per command, 0 none
  output logic             write_prep,    // Write soon
  output logic             seq_write,     // Sequential write
  output logic             seq_read,      // Sequential read
  output logic [1:0]       latency,       // Latency class
  output logic [3:0]       frequency      // Frequency code
);
  wire [3:0] af_raw = attr[ATTR_AF_LSB +: 4];

  // Field extraction; bits 23:11 and 7:6 are never looked at
  assign access_size = attr[ATTR_CAS_LSB +: 8];
  assign write_prep  = attr[ATTR_WP_BIT];
  assign seq_write   = attr[ATTR_SW_BIT];
  assign seq_read    = attr[ATTR_SR_BIT];
  assign latency     = attr[ATTR_AL_LSB +: 2];
  // Reserved codes collapse to "no information"
  assign frequency   = (af_raw <= AF_LAST_VALID) ? af_raw : 4'h0;
endmodule : drhd_attr_decode
`default_nettype wire

//--- verilog/drhd_core.sv
// Dataset range hint decoder top: registers, range list fetch, hints.
// Assumes a memory read port for the list and a consumer of hints.
//
// Overview of operation
// - Command is advisory; completion succeeds without acting on hints.
// - Only command dwords 10 and 11 hold command parameters.
// - PRP uses entries 1 and 2 for the list; SGL uses entry 1.
// - Range list is located by the 128-bit data pointer.
// - Dword 10 bits 7:0 give range count, zero based.
// - Dword 11 bit 2 permits deallocation of all ranges.
// - Descriptor: attributes bytes 3:0, length 7:4, start block 15:8.
// - At most 256 descriptors, packed, ending at byte 4095.
// - Stored data stays intact whatever the hints say.
// - Attribute bits 31:24 give access size; zero means none.
// - Attribute bit 10 marks range as written soon.
// - Attribute bit 9 marks sequential write as one object.
// - Attribute bit 8 marks sequential read as one object.
// - Attribute bits 5:4 encode latency class.
// - Attribute bits 3:0 encode access frequency; 0110b up reserved.
// - Completion posts an entry carrying command status.
// - Conflicting attributes complete with status 80h.
// - Deallocated blocks read back stable until rewritten.
`timescale 1ns/1ps
`default_nettype none
module drhd_core
  import drhd_pkg::*;
(
  input  wire logic        hclk,          // Clock, 50 MHz
  input  wire logic        hresetn,       // Async reset, low
  input  wire logic        hsel,          // AHB select
  input  wire logic [31:0] haddr,         // AHB address
  input  wire logic [1:0]  htrans,        // AHB transfer type
  input  wire logic        hwrite,        // AHB write
  input  wire logic [2:0]  hsize,         // AHB size, word only
  input  wire logic [31:0] hwdata,        // AHB write data
  input  wire logic        hready,        // AHB bus ready
  output logic             hreadyout,     // AHB slave ready
  output logic             hresp,         // AHB response, OKAY
  output logic [31:0]      hrdata,        // AHB read data
  output logic             fetch_valid,   // List word request
  input  wire logic        fetch_ready,   // Request accepted
  output logic [63:0]      fetch_addr,    // List word address
  input  wire logic        fetch_rvalid,  // Read data valid
  input  wire logic [31:0] fetch_rdata,   // Read data
  output logic             hint_valid,    // Range hint ready
  input  wire logic        hint_ready,    // Hint taken
  output logic [7:0]       hint_index,    // Range number
  output logic [63:0]      hint_slba,     // Starting block
  output logic [31:0]      hint_length,   // Length in blocks
  output logic [7:0]       hint_access_size,      // Blocks per command
  output logic             hint_write_prepare,    // Written soon
  output logic             sequential_write_hint, // Sequential write
  output logic             sequential_read_hint,  // Sequential read
  output logic [1:0]       latency_class,         // Latency class
  output logic [3:0]       access_frequency_code, // Frequency code
  output logic             integral_write_hint,   // Integral write set
  output logic             integral_read_hint,    // Integral read set
  output logic             hint_deallocate,       // May deallocate
  output logic             hint_last,     // Last range of list
  output logic             cq_valid,      // Completion ready
  input  wire logic        cq_ready,      // Completion taken
  output logic [7:0]       cq_status      // Command status
);
  typedef enum logic [2:0] {ST_IDLE, ST_REQ, ST_RESP, ST_EMIT, ST_CPL}
    drhd_state_e;

  // ********************************************************************
  // Register bus
  // ********************************************************************
  drhd_reg_if rif ();

  drhd_ahb_front u_front (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hrdata    (hrdata),
    .rif       (rif)
  );

  assign hresp = 1'b0;

  drhd_state_e  state_q;
  drhd_state_e  state_d;
  logic         conflict_en_q;
  logic         sgl_mode_q;
  logic         done_q;
  logic [31:0]  cdw10_q;
  logic [31:0]  cdw11_q;
  logic [31:0]  data_pointer_q [4];
  logic [7:0]   range_q;
  logic [1:0]   word_q;
  logic [7:0]   last_range_q;
  logic         conflict_q;
  logic [7:0]   status_q;
  logic [8:0]   processed_q;
  logic [7:0]   cas_q;
  logic         wp_q;
  logic         sw_q;
  logic         sr_q;
  logic [1:0]   al_q;
  logic [3:0]   af_q;
  logic [31:0]  len_q;
  logic [63:0]  slba_q;

  // Register write strobes
  wire wr_ctrl  = rif.wr_en & (rif.wr_idx == REG_CTRL);
  wire wr_cdw10 = rif.wr_en & (rif.wr_idx == REG_CDW10);
  wire wr_cdw11 = rif.wr_en & (rif.wr_idx == REG_CDW11);
  wire wr_data_pointer  = rif.wr_en & (rif.wr_idx >= REG_DPTR0) &
                  (rif.wr_idx <= REG_DPTR3);
  wire busy     = (state_q != ST_IDLE);
  // A start while busy is dropped: command fields must not move mid-run
  wire start    = wr_ctrl & rif.wr_data[CTRL_START_BIT] & ~busy;
  wire cfg_wr   = ~busy;

  // Read mux; dwords 10 and 11 and the four data pointer words are held as command fields
  wire [31:0] ctrl_rd   = {29'h0, sgl_mode_q, conflict_en_q, 1'b0};
  wire [31:0] status_rd = {7'h0, processed_q, status_q, 6'h0,
                           done_q, busy};
  assign rif.rd_data =
      (rif.rd_idx == REG_CTRL)   ? ctrl_rd :
      (rif.rd_idx == REG_STATUS) ? status_rd :
      (rif.rd_idx == REG_CDW10)  ? cdw10_q :
      (rif.rd_idx == REG_CDW11)  ? cdw11_q :
      (rif.rd_idx >= REG_DPTR0 && rif.rd_idx <= REG_DPTR3) ?
        data_pointer_q[rif.rd_idx[1:0]] : RST_WORD;

  // Configuration and command registers, frozen while busy
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      conflict_en_q <= 1'b0;
      sgl_mode_q    <= 1'b0;
      cdw10_q       <= RST_WORD;
      cdw11_q       <= RST_WORD;
      data_pointer_q[0]     <= RST_WORD;
      data_pointer_q[1]     <= RST_WORD;
      data_pointer_q[2]     <= RST_WORD;
      data_pointer_q[3]     <= RST_WORD;
    end
    else if (cfg_wr)
    begin
      if (wr_ctrl)
      begin
        conflict_en_q <= rif.wr_data[CTRL_CONFLICT_BIT];
        sgl_mode_q    <= rif.wr_data[CTRL_SGL_BIT];
      end
      if (wr_cdw10)
        cdw10_q <= rif.wr_data;
      if (wr_cdw11)
        cdw11_q <= rif.wr_data;
      if (wr_data_pointer)
        data_pointer_q[rif.wr_idx[1:0]] <= rif.wr_data;
    end
  end

  // ********************************************************************
  // Range list addressing
  // ********************************************************************
  // Byte offset of the current word inside the packed list
  wire [11:0] byte_off = {range_q, word_q, 2'b00};
  wire [63:0] entry1   = {data_pointer_q[1], data_pointer_q[0]};
  wire [63:0] entry2   = {data_pointer_q[3], data_pointer_q[2]};
  // Bytes of the list that fit in the first page
  wire [12:0] first_len = PAGE_BYTES - {1'b0, entry1[11:0]};
  wire        in_first  = sgl_mode_q | ({1'b0, byte_off} < first_len);
  wire [12:0] off2      = {1'b0, byte_off} - first_len;
  // A 4 KiB list spans at most two pages, so entry 2 is a plain page
  assign fetch_addr = in_first ? entry1 + {52'h0, byte_off}
                               : entry2 + {51'h0, off2};
  assign fetch_valid = (state_q == ST_REQ);

  // ********************************************************************
  // Attribute decode of the incoming word
  // ********************************************************************
  logic [7:0] dec_cas;
  logic       dec_wp;
  logic       dec_sw;
  logic       dec_sr;
  logic [1:0] dec_al;
  logic [3:0] dec_af;

  drhd_attr_decode u_decode (
    .attr        (fetch_rdata),
    .access_size (dec_cas),
    .write_prep  (dec_wp),
    .seq_write   (dec_sw),
    .seq_read    (dec_sr),
    .latency     (dec_al),
    .frequency   (dec_af)
  );

  // ********************************************************************
  // Sequencer
  // ********************************************************************
  wire word_in   = (state_q == ST_RESP) & fetch_rvalid;
  wire hint_take = (state_q == ST_EMIT) & hint_ready;
  wire is_last   = (range_q == last_range_q);
  // Deallocating a range announced as written soon is contradictory
  wire range_conflict = conflict_en_q & cdw11_q[CDW11_DEALLOC_BIT] &
                        wp_q;

  // Next state
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: if (start) state_d = ST_REQ;
      ST_REQ:  if (fetch_ready) state_d = ST_RESP;
      ST_RESP:
        if (fetch_rvalid)
          state_d = (word_q == 2'd3) ? ST_EMIT : ST_REQ;
      ST_EMIT:
        if (hint_ready)
          state_d = is_last ? ST_CPL : ST_REQ;
      ST_CPL:  if (cq_ready) state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  // State and list position
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_q      <= ST_IDLE;
      range_q      <= 8'h00;
      word_q       <= 2'd0;
      last_range_q <= 8'h00;
    end
    else
    begin
      state_q <= state_d;
      if (start)
      begin
        range_q      <= 8'h00;
        word_q       <= 2'd0;
        last_range_q <= cdw10_q[7:0]; // Zero based count
      end
      else if (word_in)
        word_q <= word_q + 2'd1;
      else if (hint_take & ~is_last)
        range_q <= range_q + 8'h01;
    end
  end

  // Descriptor words in list order: attributes, length, start block
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cas_q  <= 8'h00;
      wp_q   <= 1'b0;
      sw_q   <= 1'b0;
      sr_q   <= 1'b0;
      al_q   <= 2'd0;
      af_q   <= 4'h0;
      len_q  <= RST_WORD;
      slba_q <= 64'h0000_0000_0000_0000;
    end
    else if (word_in)
    begin
      case (word_q)
        2'd0:
        begin
          cas_q <= dec_cas;
          wp_q  <= dec_wp;
          sw_q  <= dec_sw;
          sr_q  <= dec_sr;
          al_q  <= dec_al;
          af_q  <= dec_af;
        end
        2'd1: len_q <= fetch_rdata;
        2'd2: slba_q[31:0] <= fetch_rdata;
        default: slba_q[63:32] <= fetch_rdata;
      endcase
    end
  end

  // Command outcome and progress
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      conflict_q  <= 1'b0;
      status_q    <= STATUS_OK;
      processed_q <= 9'h000;
      done_q      <= 1'b0;
    end
    else
    begin
      if (start)
      begin
        conflict_q  <= 1'b0;
        processed_q <= 9'h000;
        done_q      <= 1'b0;
      end
      else
      begin
        if (hint_take)
        begin
          conflict_q  <= conflict_q | range_conflict;
          processed_q <= processed_q + 9'h001;
        end
        if ((state_q == ST_CPL) & cq_ready)
          done_q <= 1'b1;
      end
      // Status fixed once the last hint leaves; hints never block it
      if (hint_take & is_last)
        status_q <= (conflict_q | range_conflict) ? STATUS_CONFLICT
                                                  : STATUS_OK;
    end
  end

  // ********************************************************************
  // Hint and completion outputs
  // ********************************************************************
  // Hints only steer placement elsewhere; this block never writes media
  assign hint_valid            = (state_q == ST_EMIT);
  assign hint_index            = range_q;
  assign hint_slba             = slba_q;
  assign hint_length           = len_q;
  assign hint_access_size      = cas_q;
  assign hint_write_prepare    = wp_q;
  assign sequential_write_hint = sw_q;
  assign sequential_read_hint  = sr_q;
  assign latency_class         = al_q;
  assign access_frequency_code = af_q;
  assign integral_write_hint   = cdw11_q[CDW11_IDW_BIT];
  assign integral_read_hint    = cdw11_q[CDW11_IDR_BIT];
  // Media layer must return fixed, stable data for freed blocks
  assign hint_deallocate       = cdw11_q[CDW11_DEALLOC_BIT];
  assign hint_last             = is_last;
  assign cq_valid              = (state_q == ST_CPL);
  assign cq_status             = status_q;
endmodule : drhd_core
`default_nettype wire

//--- dv/drhd_mem_model.sv
// Host memory model that serves the range list on the fetch port.
// Assumes one request outstanding, as the core promises.
`timescale 1ns/1ps
`default_nettype none
module drhd_mem_model
(
  input  wire logic        clk,     // Clock
  input  wire logic        rst_n,   // Reset, low
  input  wire logic        slow,    // Stall mode
  input  wire logic        fvalid,  // Request
  output logic             fready,  // Taken
  input  wire logic [63:0] faddr,   // Byte address
  output logic             frvalid, // Data pulse
  output logic [31:0]      frdata   // Data
);
  // ****
  // List storage, address bit 32 picks the bank
  // ****
  logic [31:0] mem [0:2047]; // Packed 16-byte descriptors
  logic        pend_q;
  logic        ph_q;
  logic [1:0]  wait_q;
  logic [10:0] idx_q;
  // Slow mode refuses every other cycle
  assign fready = ~pend_q & (~slow | ph_q);
  // Idle data toggles so a stale word never matches by luck
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      pend_q  <= 1'b0;
      ph_q    <= 1'b0;
      frvalid <= 1'b0;
      frdata  <= 32'h0000_0000;
    end
    else
    begin
      ph_q    <= ~ph_q;
      frvalid <= 1'b0;
      frdata  <= ~frdata;
      if (fvalid && fready)
      begin
        pend_q <= 1'b1;
        idx_q  <= {faddr[32], faddr[11:2]};
        wait_q <= slow ? 2'h3 : 2'h0;
      end
      else if (pend_q && wait_q != 2'h0)
        wait_q <= wait_q - 2'h1;
      else if (pend_q)
      begin
        pend_q  <= 1'b0;
        frvalid <= 1'b1;
        frdata  <= mem[idx_q];
      end
    end
endmodule : drhd_mem_model
`default_nettype wire

//--- dv/drhd_checker.sv
// Port checker for the range hint decoder core.
// Assumes it is bound to the core and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module drhd_checker
(
  input wire logic        hclk,                  // Clock
  input wire logic        hresetn,               // Reset, low
  input wire logic        hsel,                  // Select
  input wire logic [1:0]  htrans,                // Transfer
  input wire logic        hwrite,                // Write
  input wire logic        hready,                // Bus ready
  input wire logic        hreadyout,             // Slave ready
  input wire logic        hresp,                 // Response
  input wire logic        fetch_valid,           // List request
  input wire logic        fetch_ready,           // Taken
  input wire logic [63:0] fetch_addr,            // Word address
  input wire logic        hint_valid,            // Hint out
  input wire logic        hint_ready,            // Hint taken
  input wire logic [7:0]  hint_index,            // Range number
  input wire logic [63:0] hint_slba,             // Start block
  input wire logic [31:0] hint_length,           // Length
  input wire logic [3:0]  access_frequency_code, // Frequency
  input wire logic        hint_deallocate,       // Dealloc flag
  input wire logic        hint_last,             // Last range
  input wire logic        cq_valid,              // Completion
  input wire logic        cq_ready,              // Taken
  input wire logic [7:0]  cq_status              // Status
);
  // ****
  // Index tracking and properties
  // ****
  logic [7:0] nxt_q;
  // Next expected index; a last range restarts at zero
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      nxt_q <= 8'h00;
    else if (hint_valid && hint_ready)
      nxt_q <= hint_last ? 8'h00 : hint_index + 8'h01;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("response not okay");
  a_read_wait: assert property (hsel && htrans[1] && !hwrite && hready
    && hreadyout |=> !hreadyout ##1 hreadyout) else $error("read wait");
  a_write_nowait: assert property (hsel && htrans[1] && hwrite && hready
    && hreadyout |=> hreadyout) else $error("write wait");
  a_fetch_hold: assert property (fetch_valid && !fetch_ready
    |=> fetch_valid && $stable(fetch_addr)) else $error("fetch dropped");
  a_fetch_align: assert property (fetch_valid
    |-> fetch_addr[1:0] == 2'b00) else $error("fetch unaligned");
  a_hint_hold: assert property (hint_valid && !hint_ready |=> hint_valid
    && $stable({hint_slba, hint_length})) else $error("hint moved");
  a_hint_order: assert property (hint_valid
    |-> hint_index == nxt_q) else $error("hint order");
  a_freq_code: assert property (hint_valid
    |-> access_frequency_code <= 4'h5) else $error("reserved frequency");
  a_cq_after_last: assert property (hint_valid && hint_ready
    && hint_last |-> ##[1:4] cq_valid) else $error("no completion");
  a_cq_hold: assert property (cq_valid && !cq_ready |=> cq_valid
    && $stable(cq_status)) else $error("completion moved");
  a_conflict_code: assert property (cq_valid |-> cq_status == 8'h00
    || (cq_status == 8'h80 && hint_deallocate)) else $error("bad status");
  cover property (cq_valid && cq_status == 8'h80);
  cover property (hint_valid && hint_ready && hint_index == 8'hff);
  cover property (fetch_valid && !fetch_ready);
endmodule : drhd_checker
bind drhd_core drhd_checker drhd_checker_i (.*);
`default_nettype wire

//--- dv/dataset_range_hint_decoder_test.sv
// Self-checking bench for the range hint decoder core.
// Assumes the list memory model and the bound port checker.
`timescale 1ns/1ps
`default_nettype none
module dataset_range_hint_decoder_test;
  import drhd_pkg::*;
  // ****
  // Signals and instances
  // ****
  logic        hclk = 0, hresetn = 0, hsel = 1'b1, hwrite = 0, slow = 0;
  logic        hint_ready = 0, cq_ready = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, fetch_rdata, hint_length, rd;
  logic [1:0]  htrans = 0, latency_class;
  logic [2:0]  hsize = 3'h2;
  logic [63:0] fetch_addr, hint_slba;
  logic [7:0]  hint_index, hint_access_size, cq_status;
  logic [3:0]  access_frequency_code;
  logic        hreadyout, hresp, fetch_valid, fetch_ready, fetch_rvalid;
  logic        hint_valid, hint_write_prepare, sequential_write_hint;
  logic        sequential_read_hint, integral_write_hint, integral_read_hint;
  logic        hint_deallocate, hint_last, cq_valid;
  logic [15:0] lf = 16'h003c;
  logic [31:0] ea [256], el [256];
  logic [63:0] es [256];
  int          n_mismatch = 0, checks = 0;
  drhd_core drhd_core_i (.hready(hreadyout), .*);
  drhd_mem_model drhd_mem_model_i (.clk(hclk), .rst_n(hresetn), .slow,
    .fvalid(fetch_valid), .fready(fetch_ready), .faddr(fetch_addr),
    .frvalid(fetch_rvalid), .frdata(fetch_rdata));
  always #10 hclk = ~hclk;
  // ****
  // Helpers
  // ****
  function automatic logic [31:0] rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return {lf, lf[7:0], lf[15:8]};
  endfunction : rnd
  // Reserved frequency codes read as none
  function automatic logic [3:0] fq(input logic [31:0] a);
    return (a[3:0] > 4'h5) ? 4'h0 : a[3:0];
  endfunction : fq
  task automatic chk(input string nm, input logic [63:0] seen, exp);
    checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("FAIL %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // One AHB single transfer; read data lands in rd
  task automatic ahb(input logic w, input logic [31:0] a, d);
    @(posedge hclk);
    htrans <= HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    do @(negedge hclk); while (hreadyout !== 1'b1);
    @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    do @(negedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    @(posedge hclk);
  endtask : ahb
  // Whole command: list, registers, hints, completion, status
  task automatic run(input logic [31:0] c10, c11, input logic [2:0] ct,
                     input logic [63:0] e1, e2, input logic wp);
    int n, k, o;
    logic cf = 0;
    logic [7:0] st;
    logic [63:0] a;
    n = c10[7:0];
    for (k = 0; k <= n; k++)
    begin
      ea[k] = rnd();
      if (!wp) ea[k][10] = 1'b0;
      el[k] = rnd();
      es[k] = {rnd(), rnd()};
      cf |= ea[k][10];
      // PRP lists split at the first page end
      for (int w = 0; w < 4; w++)
      begin
        o = k * 16 + w * 4;
        a = (ct[2] || o < 4096 - e1[11:0]) ? e1 + o
          : e2 + o - (4096 - e1[11:0]);
        drhd_mem_model_i.mem[{a[32], a[11:2]}] =
          32'({es[k], el[k], ea[k]} >> 32 * w);
      end
    end
    st = (ct[1] && c11[2] && cf) ? 8'h80 : 8'h00;
    slow <= c10[8];
    for (int i = 0; i < 6; i++)
      ahb(1, 32'h0000_0008 + 4 * i, 32'({e2, e1, c11, c10} >> 32 * i));
    ahb(1, 32'h0000_0000, {29'h0, ct});
    ahb(0, 32'h0000_0004, 0);
    chk("busy", rd[0], 1);
    ahb(1, 32'h0000_0008, ~c10);
    k = 0;
    for (int g = 0; g < 20000 && k <= n; g++)
    begin
      @(posedge hclk);
      hint_ready <= lf[0];
      void'(rnd());
      @(negedge hclk);
      if (hint_valid === 1'b1 && hint_ready)
      begin
        chk("slba", hint_slba, es[k]);
        chk("len", {hint_index, hint_length}, {8'(k), el[k]});
        chk("attr", {hint_access_size, hint_write_prepare,
          sequential_write_hint, sequential_read_hint, latency_class,
          access_frequency_code}, {ea[k][31:24], ea[k][10:8],
          ea[k][5:4], fq(ea[k])});
        chk("flags", {integral_write_hint, integral_read_hint,
          hint_deallocate, hint_last}, {c11[1:0], c11[2], k == n});
        k++;
      end
    end
    @(posedge hclk);
    hint_ready <= 1'b0;
    cq_ready <= 1'b1;
    for (k = 0; k < 8 && cq_valid !== 1'b1; k++) @(negedge hclk);
    chk("completion", {cq_valid, cq_status}, {1'b1, st});
    @(posedge hclk);
    cq_ready <= 1'b0;
    ahb(0, 32'h0000_0004, 0);
    chk("status", rd & 32'h01ff_ff03, {7'h0, 9'(n + 1), st, 8'h02});
    ahb(0, 32'h0000_0008, 0);
    chk("cdw10", rd[7:0], c10[7:0]);
  endtask : run
  task automatic test_done();
    if (n_mismatch == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  // ****
  // Scenarios: one range, page split, SGL, random
  // ****
  initial
  begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    run(32'h0000_0000, 32'h0000_0000, 3'h1, 64'h0000_3000, 64'h0, 1);
    run(32'hffff_ffff, 32'hffff_ffff, 3'h3, 64'h0000_2f00,
        64'h0001_0000_5000, 1);
    run(32'h0000_0009, 32'h0000_0004, 3'h7, 64'h0001_0000_0fc0,
        64'h0000_7000, 0);
    run({28'h0, lf[3:0]}, 32'h0000_0002, 3'h1, 64'h0000_4000, 64'h0, 1);
    ahb(0, 32'h0000_0040, 0);
    chk("unmapped", rd, 0);
    test_done();
  end
  // Watchdog
  initial
  begin
    repeat (60000) @(posedge hclk);
    n_mismatch++;
    test_done();
  end
endmodule : dataset_range_hint_decoder_test
`default_nettype wire
